// ==== rtcs_bcd_time.v ====
// bcd calendar counter advanced one second per tick, loadable
`timescale 1ns/1ps
`default_nettype none
module rtcs_bcd_time (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        tick,
    input  wire        load,
    input  wire [55:0] load_val,
    output reg  [55:0] time_q
);
    function [7:0] bcd_inc;
        input [7:0] v;
        begin
            if (v[3:0] >= 4'h9)
                bcd_inc = {v[7:4] + 4'h1, 4'h0};
            else
                bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction
    function [7:0] mdays;
        input [7:0] mon;
        input [7:0] yr;
        reg         leap;
        begin
            leap = ((yr[4] ? 1'b1 : 1'b0) ^ 1'b0) ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
            case (mon)
                8'h02:   mdays = leap ? 8'h29 : 8'h28;
                8'h04, 8'h06, 8'h09, 8'h11: mdays = 8'h30;
                default: mdays = 8'h31;
            endcase
        end
    endfunction
    wire [7:0] sec  = {1'b0, time_q[6:0]};
    wire [7:0] mnt  = time_q[15:8];
    wire [7:0] hr   = time_q[23:16];
    wire [7:0] wd   = time_q[31:24];
    wire [7:0] dt   = time_q[39:32];
    wire [7:0] mo   = time_q[47:40];
    wire [7:0] yr   = time_q[55:48];
    reg  [55:0] time_d;
    always @* begin
        time_d = time_q;
        if (load)
            time_d = load_val;
        else if (tick) begin
            time_d[7:0] = bcd_inc(sec);
            if (sec == 8'h59) begin
                time_d[7:0] = 8'h00;
                time_d[15:8] = bcd_inc(mnt);
                if (mnt == 8'h59) begin
                    time_d[15:8] = 8'h00;
                    time_d[23:16] = bcd_inc(hr);
                    if (hr == 8'h23) begin
                        time_d[23:16] = 8'h00;
                        time_d[31:24] = (wd == 8'h07) ? 8'h01 : bcd_inc(wd);
                        time_d[39:32] = bcd_inc(dt);
                        if (dt >= mdays(mo, yr)) begin
                            time_d[39:32] = 8'h01;
                            time_d[47:40] = bcd_inc(mo);
                            if (mo == 8'h12) begin
                                time_d[47:40] = 8'h01;
                                time_d[55:48] = (yr == 8'h99) ? 8'h00 : bcd_inc(yr);
                            end
                        end
                    end
                end
            end
        end
    end
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            time_q <= 56'h0001_0101_0000_00;
        else
            time_q <= time_d;
    end
endmodule // rtcs_bcd_time
`default_nettype wire

// ==== rtcs_host.sv ====
// host bus model for the clock sram
`timescale 1ns/1ps
`default_nettype none
module rtcs_host (
    input  wire logic        ref_clk,
    output logic             select_low_n,
    output logic             select_high,
    output logic             write_n,
    output logic             out_en_n,
    output logic [12:0]      address_bus,
    output logic [7:0]       data_bus_in,
    input  wire logic [7:0]  data_bus_out,
    input  wire logic        data_bus_oe
);
    initial {select_low_n, select_high, write_n, out_en_n, address_bus, data_bus_in} = {4'b1011, 21'h00_0000};
    // en: strobe, low select, high select
    task automatic wr(input logic [12:0] a, input logic [7:0] v, input logic [2:0] en);
        @(negedge ref_clk) {address_bus, data_bus_in} = {a, v};
        {select_low_n, select_high, write_n, out_en_n} = {!en[1], en[0], !en[2], 1'b1};
        repeat (2) @(negedge ref_clk);
        {select_low_n, select_high, write_n} = 3'b101;
        @(negedge ref_clk) data_bus_in = ~v;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [12:0] a, output logic [7:0] v, output logic oe);
        @(negedge ref_clk) address_bus = a;
        {select_low_n, select_high, write_n, out_en_n} = 4'b0110;
        repeat (2) @(negedge ref_clk);
        // a floating bus reads back inverted
        @(negedge ref_clk) {v, oe} = {data_bus_oe ? data_bus_out : ~data_bus_out, data_bus_oe};
        {select_low_n, select_high, out_en_n} = 3'b101;
    endtask
endmodule // rtcs_host
`default_nettype wire

// ==== rtcs_regs.vh ====
// register map, field positions and timing counts for the clock sram
`ifndef RTCS_REGS_VH
`define RTCS_REGS_VH
`define RTCS_ADDR_W        13
`define RTCS_CTRL_ADDR     13'h1ff8
`define RTCS_SEC_ADDR      13'h1ff9
`define RTCS_MIN_ADDR      13'h1ffa
`define RTCS_HOUR_ADDR     13'h1ffb
`define RTCS_WDAY_ADDR     13'h1ffc
`define RTCS_DATE_ADDR     13'h1ffd
`define RTCS_MON_ADDR      13'h1ffe
`define RTCS_YEAR_ADDR     13'h1fff
`define RTCS_CTRL_SET_BIT  7
`define RTCS_CTRL_HOLD_BIT 6
`define RTCS_CTRL_SIGN_BIT 5
`define RTCS_SEC_HALT_BIT  7
`define RTCS_WDAY_FT_BIT   6
`define RTCS_CLK_HZ        10000000
`define RTCS_SEC_CYCLES    10000000
`define RTCS_PF_DELAY_NS   10000
`define RTCS_PF_CYCLES     ((`RTCS_PF_DELAY_NS * 10 + 999) / 1000)
`define RTCS_REC_CYCLES    2000000
`define RTCS_CAL_STEP      128
`endif

// ==== rtcs_top.v ====
// byte-wide sram with clock registers, power-fail deselect and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "rtcs_regs.vh"
module rtcs_top #(
    parameter integer SEC_CYCLES = `RTCS_SEC_CYCLES,
    parameter integer REC_CYCLES = `RTCS_REC_CYCLES,
    parameter integer PF_CYCLES  = `RTCS_PF_CYCLES
) (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        select_low_n,
    input  wire        select_high,
    input  wire        write_n,
    input  wire        out_en_n,
    input  wire [12:0] address_bus,
    input  wire [7:0]  data_bus_in,
    output reg  [7:0]  data_bus_out,
    output wire        data_bus_oe,
    input  wire        pf_trip,
    input  wire        in_deselect_window,
    output wire        pf_int_out,
    output wire        pf_int_oe
);
    localparam ST_RUN  = 2'b00;
    localparam ST_WARN = 2'b01;
    localparam ST_DSEL = 2'b10;
    localparam ST_REC  = 2'b11;
    localparam [7:0] SEC_MASK = 8'h7f;
    // clock register area decode, shared by read and write paths
    function in_clk_area;
        input [12:0] a;
        begin
            in_clk_area = (a >= `RTCS_CTRL_ADDR);
        end
    endfunction
    reg  [7:0]  mem [0:8183];
    reg  [7:0]  ctrl_q;
    reg  [55:0] shadow_q;
    reg  [1:0]  pf_state_q;
    reg  [31:0] pf_cnt_q;
    reg  [31:0] div_q;
    reg         wr_active_q;
    reg         set_was_q;
    reg         upd_pend_q;
    reg  [5:0]  cal_min_q;
    reg  [7:0]  wr_data_q;
    reg  [12:0] wr_addr_q;
    wire [55:0] count_q;
    // window input blocks at once, state keeps blocking through recovery
    wire        protect = in_deselect_window || (pf_state_q == ST_DSEL) || (pf_state_q == ST_REC);
    wire        enabled = !select_low_n && select_high && !protect;
    wire        wr_on   = enabled && !write_n;
    wire        is_clk  = in_clk_area(address_bus);
    wire        halted  = shadow_q[7];
    wire        set_bit = ctrl_q[`RTCS_CTRL_SET_BIT];
    wire        hold    = ctrl_q[`RTCS_CTRL_HOLD_BIT] | set_bit;
    wire [4:0]  cal_mag = ctrl_q[4:0];
    wire        cal_pos = ctrl_q[`RTCS_CTRL_SIGN_BIT];
    wire        cal_act = (cal_min_q < {cal_mag, 1'b0}) && (cal_mag != 5'h00) && (cal_min_q < 6'd62);
    wire [31:0] sec_len = cal_act ? (cal_pos ? SEC_CYCLES - `RTCS_CAL_STEP : SEC_CYCLES + 2 * `RTCS_CAL_STEP)
                                  : SEC_CYCLES;
    wire        tick    = !halted && (div_q >= sec_len - 1);
    wire        load_cnt = set_was_q && !set_bit;
    assign data_bus_oe = enabled && write_n && !out_en_n;
    assign pf_int_out  = 1'b0;
    assign pf_int_oe   = (pf_state_q != ST_RUN);
    rtcs_bcd_time u_time (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .tick     (tick),
        .load     (load_cnt),
        .load_val ({shadow_q[55:8], shadow_q[7:0] & SEC_MASK}),
        .time_q   (count_q)
    );
    // power-fail sequencing
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pf_state_q <= ST_RUN;
            pf_cnt_q   <= 32'h0000_0000;
        end else begin
            case (pf_state_q)
                ST_RUN: begin
                    pf_cnt_q <= 32'h0000_0000;
                    if (in_deselect_window)
                        pf_state_q <= ST_DSEL;
                    else if (pf_trip)
                        pf_state_q <= ST_WARN;
                end
                ST_WARN: begin
                    pf_cnt_q <= pf_cnt_q + 32'h0000_0001;
                    if (in_deselect_window || pf_cnt_q >= PF_CYCLES - 1)
                        pf_state_q <= ST_DSEL;
                    else if (!pf_trip)
                        pf_state_q <= ST_RUN;
                end
                ST_DSEL: begin
                    pf_cnt_q <= 32'h0000_0000;
                    if (!in_deselect_window && !pf_trip)
                        pf_state_q <= ST_REC;
                end
                ST_REC: begin
                    pf_cnt_q <= pf_cnt_q + 32'h0000_0001;
                    if (in_deselect_window || pf_trip) begin
                        pf_state_q <= ST_DSEL;
                        pf_cnt_q   <= 32'h0000_0000;
                    end else if (pf_cnt_q >= REC_CYCLES - 1)
                        pf_state_q <= ST_RUN;
                end
                default: pf_state_q <= ST_RUN;
            endcase
        end
    end
    // write capture: data is committed at the end of the write
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_active_q <= 1'b0;
            wr_data_q   <= 8'h00;
            wr_addr_q   <= 13'h0000;
        end else begin
            wr_active_q <= wr_on;
            if (wr_on) begin
                wr_data_q <= data_bus_in;
                wr_addr_q <= address_bus;
            end
        end
    end
    // a write cut by deselect only leaves the latched byte of one address
    wire commit = wr_active_q && !wr_on;
    wire commit_clk = commit && in_clk_area(wr_addr_q);
    always @(posedge ref_clk) begin
        if (commit && !commit_clk)
            mem[wr_addr_q] <= wr_data_q;
    end
    // second divider and calibration minute
    reg [5:0] sec_in_min_q;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_q        <= 32'h0000_0000;
            sec_in_min_q <= 6'd0;
            cal_min_q    <= 6'd0;
        end else if (halted || load_cnt) begin
            div_q <= 32'h0000_0000;
        end else if (tick) begin
            div_q <= 32'h0000_0000;
            if (sec_in_min_q == 6'd59) begin
                sec_in_min_q <= 6'd0;
                cal_min_q    <= cal_min_q + 6'd1;
            end else
                sec_in_min_q <= sec_in_min_q + 6'd1;
        end else
            div_q <= div_q + 32'h0000_0001;
    end
    // clock register file; counter copy lands as one word
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q     <= 8'h00;
            shadow_q   <= 56'h0001_0101_0000_00;
            set_was_q  <= 1'b0;
            upd_pend_q <= 1'b0;
        end else begin
            set_was_q <= set_bit;
            if (commit_clk) begin
                case (wr_addr_q[2:0])
                    3'd0: ctrl_q <= wr_data_q;
                    3'd1: shadow_q[7:0]   <= wr_data_q;
                    3'd2: shadow_q[15:8]  <= wr_data_q;
                    3'd3: shadow_q[23:16] <= wr_data_q;
                    3'd4: shadow_q[31:24] <= wr_data_q;
                    3'd5: shadow_q[39:32] <= wr_data_q;
                    3'd6: shadow_q[47:40] <= wr_data_q;
                    default: shadow_q[55:48] <= wr_data_q;
                endcase
            end else if (upd_pend_q && !hold && !load_cnt) begin
                // copy the cycle after the tick, once the counters have settled
                // halt and test bits stay software owned
                shadow_q   <= {count_q[55:32], count_q[31:24] & 8'h07 | (shadow_q[31:24] & 8'h40),
                               count_q[23:8], shadow_q[7], count_q[6:0]};
                upd_pend_q <= 1'b0;
            end
            // a tick in the copy cycle stays pending
            if (tick)
                upd_pend_q <= 1'b1;
        end
    end
    // read path: seconds lsb toggles at test rate when test bit set
    reg [8:0] ft_div_q;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            ft_div_q <= 9'h000;
        else
            ft_div_q <= ft_div_q + 9'h001;
    end
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            data_bus_out <= 8'h00;
        else if (is_clk) begin
            case (address_bus[2:0])
                3'd0: data_bus_out <= ctrl_q;
                3'd1: data_bus_out <= shadow_q[24 + `RTCS_WDAY_FT_BIT] ? {shadow_q[7:1], ft_div_q[8]}
                                                                     : shadow_q[7:0];
                3'd2: data_bus_out <= shadow_q[15:8];
                3'd3: data_bus_out <= shadow_q[23:16];
                3'd4: data_bus_out <= shadow_q[31:24];
                3'd5: data_bus_out <= shadow_q[39:32];
                3'd6: data_bus_out <= shadow_q[47:40];
                default: data_bus_out <= shadow_q[55:48];
            endcase
        end else
            data_bus_out <= mem[address_bus];
    end
endmodule // rtcs_top
`default_nettype wire

// ==== rtcs_top_assertions.sv ====
// port checker for the clock sram
`timescale 1ns/1ps
`default_nettype none
module rtcs_top_chk #(parameter integer SEC_CYCLES = 100, REC_CYCLES = 20, PF_CYCLES = 100) (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        select_low_n,
    input wire logic        select_high,
    input wire logic        write_n,
    input wire logic        out_en_n,
    input wire logic [12:0] address_bus,
    input wire logic [7:0]  data_bus_out,
    input wire logic        data_bus_oe,
    input wire logic        pf_trip,
    input wire logic        in_deselect_window,
    input wire logic        pf_int_out,
    input wire logic        pf_int_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    integer rec_q;
    integer pf_q;
    wire    rd_act = !select_low_n && select_high && write_n && !out_en_n;
    // recovery countdown with margin, trip length
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rec_q <= 0;
            pf_q  <= 0;
        end else begin
            rec_q <= (pf_trip || in_deselect_window) ? REC_CYCLES + 3 : rec_q - (rec_q != 0);
            pf_q  <= !pf_trip ? 0 : pf_q + (pf_q < 1000);
        end
    end
    sequence s_read_steady;
        (rd_act && $stable(address_bus) && address_bus < 13'h1ff8 && rec_q == 0 && !pf_trip)[*2];
    endsequence
    property p_oe_cause; data_bus_oe |-> rd_act && !in_deselect_window; endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("driven outside read");
    property p_read_drives; rd_act && rec_q == 0 && !pf_trip && !in_deselect_window |-> data_bus_oe; endproperty
    a_read_drives: assert property (p_read_drives) else $error("read not driven");
    property p_read_steady; s_read_steady |-> $stable(data_bus_out); endproperty
    a_read_steady: assert property (p_read_steady) else $error("read data moved");
    property p_int_now; $rose(pf_trip) |-> ##[0:1] pf_int_oe; endproperty
    a_int_now: assert property (p_int_now) else $error("interrupt late");
    property p_int_drain; !pf_int_out; endproperty
    a_int_drain: assert property (p_int_drain) else $error("interrupt driven high");
    property p_auto_desel; pf_q >= 400 |-> !data_bus_oe; endproperty
    a_auto_desel: assert property (p_auto_desel) else $error("no auto deselect");
    property p_window_float; in_deselect_window |-> !data_bus_oe; endproperty
    a_window_float: assert property (p_window_float) else $error("driven in window");
    property p_rec_float; !pf_trip && !in_deselect_window && rec_q > 5 |-> !data_bus_oe; endproperty
    a_rec_float: assert property (p_rec_float) else $error("driven in recovery");
endmodule // rtcs_top_chk
bind rtcs_top rtcs_top_chk #(.SEC_CYCLES(SEC_CYCLES), .REC_CYCLES(REC_CYCLES), .PF_CYCLES(PF_CYCLES)) chk_u (
    .ref_clk(ref_clk), .rstn(rstn), .select_low_n(select_low_n), .select_high(select_high), .write_n(write_n),
    .out_en_n(out_en_n), .address_bus(address_bus), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .pf_trip(pf_trip), .in_deselect_window(in_deselect_window), .pf_int_out(pf_int_out), .pf_int_oe(pf_int_oe));
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the clock sram
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
module testbench;
    localparam integer SEC = 100;
    logic        ref_clk = 1'b0;
    logic        rstn, select_low_n, select_high, write_n, out_en_n, data_bus_oe;
    logic        pf_trip, in_deselect_window, pf_int_out, pf_int_oe, oe;
    logic [12:0] address_bus;
    logic [7:0]  data_bus_in, data_bus_out, d, s0;
    logic [2:0]  part [3] = '{3'h3, 3'h5, 3'h6};
    integer      failures = 0, n_tests = 0, cycles = 0;
    always #50 ref_clk = ~ref_clk;
    rtcs_host host_u (.ref_clk(ref_clk), .select_low_n(select_low_n), .select_high(select_high), .write_n(write_n),
        .out_en_n(out_en_n), .address_bus(address_bus), .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
        .data_bus_oe(data_bus_oe));
    rtcs_top #(.SEC_CYCLES(SEC), .REC_CYCLES(20)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .select_low_n(select_low_n),
        .select_high(select_high), .write_n(write_n), .out_en_n(out_en_n), .address_bus(address_bus),
        .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .pf_trip(pf_trip),
        .in_deselect_window(in_deselect_window), .pf_int_out(pf_int_out), .pf_int_oe(pf_int_oe));
    task automatic test_done;
        $display("failures %0d of %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic w(input logic [12:0] a, input logic [7:0] v);
        host_u.wr(a, v, 3'h7);
    endtask
    task automatic rc(input logic [12:0] a, input logic [7:0] v);
        host_u.rd(a, d, oe);
        `CHK(d, v)
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            test_done;
        end
    end
    initial begin
        {rstn, pf_trip, in_deselect_window} = 3'b000;
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        for (int i = 0; i < 4; i++)
            rc(13'h1ffc + 13'(i), (i == 3) ? 8'h00 : 8'h01);
        `CHK(oe, 1'b1)
        w(13'h0000, 8'ha5);
        w(13'h1ff7, 8'h5a);
        rc(13'h0000, 8'ha5);
        rc(13'h1ff7, 8'h5a);
        foreach (part[k]) begin
            host_u.wr(13'h0000, 8'h3c, part[k]);
            rc(13'h0000, 8'ha5);
        end
        w(13'h1ff8, 8'h80);
        w(13'h1ff9, 8'h45);
        w(13'h1ffa, 8'h59);
        w(13'h1ffb, 8'h23);
        w(13'h1ff8, 8'h00);
        repeat (SEC + 50) @(negedge ref_clk);
        w(13'h1ff8, 8'h40);
        rc(13'h1ffa, 8'h59);
        rc(13'h1ffb, 8'h23);
        host_u.rd(13'h1ff9, s0, oe);
        `CHK(s0 == 8'h46 || s0 == 8'h47, 1'b1)
        repeat (2 * SEC + 50) @(negedge ref_clk);
        rc(13'h1ff9, s0);
        w(13'h1ff8, 8'h00);
        // counters ran on through the hold: three more seconds show at once
        rc(13'h1ff9, 8'h49);
        repeat (SEC + 20) @(negedge ref_clk);
        rc(13'h1ff9, 8'h50);
        pf_trip = 1'b1;
        @(negedge ref_clk);
        `CHK(pf_int_oe, 1'b1)
        `CHK(pf_int_out, 1'b0)
        rc(13'h0000, 8'ha5);
        `CHK(oe, 1'b1)
        repeat (400) @(negedge ref_clk);
        host_u.rd(13'h0000, d, oe);
        `CHK(oe, 1'b0)
        in_deselect_window = 1'b1;
        w(13'h0000, 8'h11);
        {pf_trip, in_deselect_window} = 2'b00;
        w(13'h0000, 8'h22);
        repeat (30) @(negedge ref_clk);
        rc(13'h0000, 8'ha5);
        rc(13'h1ff7, 8'h5a);
        w(13'h0000, 8'h77);
        rc(13'h0000, 8'h77);
        // test bit set: seconds lsb flips every 256 cycles
        w(13'h1ffc, 8'h41);
        host_u.rd(13'h1ff9, s0, oe);
        repeat (252) @(negedge ref_clk);
        host_u.rd(13'h1ff9, d, oe);
        `CHK(d[0] ^ s0[0], 1'b1)
        w(13'h1ffc, 8'h01);
        test_done;
    end
endmodule // testbench
`default_nettype wire
